// >>> shared/tpc_pkg.sv
// Constants, types and line mapping shared by both ends of the trace port capture link.
// Assumes a 10 MHz system clock on both ends and a trace port clock made by the target end.
package tpc_pkg;

   // ***********************************************
   // Modes
   // ***********************************************
   typedef enum logic [1:0] {TPC_ARCH_V1, TPC_ARCH_V2, TPC_ARCH_V3} tpc_arch_t;
   typedef enum logic [1:0] {TPC_W4, TPC_W8, TPC_W16} tpc_width_t;

   // ***********************************************
   // Line layout (line n sits at bit n-1)
   // ***********************************************
   localparam int TPC_LINES    = 20;
   localparam int TPC_PAY_W    = 16;
   localparam int TPC_STAT_W   = 4;
   localparam int TPC_L_STAT0  = 0;
   localparam int TPC_V1_STW   = 3;
   localparam int TPC_L_SYNC   = 3;
   localparam int TPC_L_PKT0   = 4;
   localparam int TPC_L_DAT0   = 0;
   localparam int TPC_L_CTL    = 1;
   localparam int TPC_L_ONE    = 2;
   localparam int TPC_L_ZERO0  = 3;
   localparam int TPC_L_ZERO1  = 4;
   localparam int TPC_L_DAT1   = 5;
   localparam logic [15:0] TPC_MASK_W4  = 16'h000f;
   localparam logic [15:0] TPC_MASK_W8  = 16'h00ff;
   localparam logic [15:0] TPC_MASK_W16 = 16'hffff;

   typedef struct packed {
      logic [TPC_STAT_W-1:0] pipeline_status;
      logic                  branch_sync_marker;
      logic                  trace_valid_control;
      logic [TPC_PAY_W-1:0]  payload;
   } tpc_sample_t;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam longint TPC_SYS_CLK_HZ   = 64'd10_000_000;
   localparam longint TPC_TCLK_MIN_HZ  = 64'd1_000_000;
   localparam longint TPC_TCLK_MAX_HZ  = 64'd200_000_000;
   localparam longint TPC_HALF_MAX_HZ  = 64'd100_000_000;
   localparam longint TPC_TCLK_HZ      = 64'd1_250_000;
   localparam int     TPC_TCLK_HALF    = int'(TPC_SYS_CLK_HZ / (2 * TPC_TCLK_HZ));
   localparam int     TPC_FIFO_DEPTH   = 32;

   function automatic logic [15:0] tpc_mask(tpc_width_t w);
      case (w)
         TPC_W4:  return TPC_MASK_W4;
         TPC_W8:  return TPC_MASK_W8;
         default: return TPC_MASK_W16;
      endcase
   endfunction

   function automatic tpc_sample_t tpc_decode(logic [TPC_LINES-1:0] l, tpc_arch_t a,
                                              logic [15:0] m);
      tpc_sample_t s;
      s = '0;
      case (a)
         TPC_ARCH_V1: begin
            s.pipeline_status[TPC_V1_STW-1:0] = l[TPC_L_STAT0 +: TPC_V1_STW];
            s.branch_sync_marker               = l[TPC_L_SYNC];
            s.payload                          = l[TPC_L_PKT0 +: TPC_PAY_W] & m;
         end
         TPC_ARCH_V2: begin
            s.pipeline_status = l[TPC_L_STAT0 +: TPC_STAT_W];
            s.payload         = l[TPC_L_PKT0 +: TPC_PAY_W] & m;
         end
         TPC_ARCH_V3: begin
            s.trace_valid_control = l[TPC_L_CTL];
            s.payload = {l[TPC_L_DAT1 +: TPC_PAY_W-1], l[TPC_L_DAT0]} & m;
         end
         default: s = '0;
      endcase
      return s;
   endfunction

   function automatic logic [TPC_LINES-1:0] tpc_encode(tpc_sample_t s, tpc_arch_t a);
      logic [TPC_LINES-1:0] l;
      l = '0;
      case (a)
         TPC_ARCH_V1: begin
            l[TPC_L_STAT0 +: TPC_V1_STW] = s.pipeline_status[TPC_V1_STW-1:0];
            l[TPC_L_SYNC]                = s.branch_sync_marker;
            l[TPC_L_PKT0 +: TPC_PAY_W]   = s.payload;
         end
         TPC_ARCH_V2: begin
            l[TPC_L_STAT0 +: TPC_STAT_W] = s.pipeline_status;
            l[TPC_L_PKT0 +: TPC_PAY_W]   = s.payload;
         end
         TPC_ARCH_V3: begin
            l[TPC_L_DAT0]                  = s.payload[0];
            l[TPC_L_CTL]                   = s.trace_valid_control;
            l[TPC_L_ONE]                   = 1'b1;
            l[TPC_L_ZERO0]                 = 1'b0;
            l[TPC_L_ZERO1]                 = 1'b0;
            l[TPC_L_DAT1 +: TPC_PAY_W-1]   = s.payload[TPC_PAY_W-1:1];
         end
         default: l = '0;
      endcase
      return l;
   endfunction

endpackage

// >>> shared/tpc_if.sv
// Connector between probe end and target end: trace lines, JTAG and run control.
// Assumes the bench instantiates it once and joins both ends through the modports.
interface tpc_if;
   import tpc_pkg::*;

   logic                 trace_port_clock;
   logic [TPC_LINES-1:0] trace_lines;
   logic                 tck;
   logic                 tms;
   logic                 tdi;
   logic                 trst_n;
   logic                 tdo;
   logic                 returned_test_clock;
   logic                 halt_request;
   logic                 halt_acknowledge;
   logic                 sys_reset_o;
   logic                 sys_reset_oe;
   logic                 sys_reset_n;

   // Open-collector wire with target pull-up; trigger line deliberately absent
   assign sys_reset_n = !(sys_reset_oe && !sys_reset_o);

   modport probe (
      input  trace_port_clock, trace_lines, tdo, returned_test_clock, halt_acknowledge,
      output tck, tms, tdi, trst_n, halt_request, sys_reset_o, sys_reset_oe
   );
   modport target (
      output trace_port_clock, trace_lines, tdo, returned_test_clock, halt_acknowledge,
      input  tck, tms, tdi, trst_n, halt_request, sys_reset_n
   );
endinterface

// >>> verilog/tpc_probe.sv
// Probe end: trace capture on the trace port clock, dual-clock FIFO, run control.
// Assumes the target end makes the trace port clock and keeps its line mapping.

// ***********************************************
// Dual-clock FIFO with gray-coded pointers
// ***********************************************
module tpc_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 32
) (
   // Write side
   input  wire logic         wr_clk,
   input  wire logic         wr_rst_n,
   input  wire logic         wr_valid,
   output logic              wr_ready,
   input  wire logic [W-1:0] wr_data,
   // Read side
   input  wire logic         rd_clk,
   input  wire logic         rd_rst_n,
   output logic              rd_valid,
   input  wire logic         rd_ready,
   output logic [W-1:0]      rd_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wbin_r, rbin_r, wgray_r, rgray_r;
   logic [AW:0]  rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
   logic [AW:0]  wbin_nxt, rbin_nxt;
   wire          do_wr = wr_valid && wr_ready;
   wire          do_rd = rd_valid && rd_ready;

   assign wbin_nxt = wbin_r + (AW+1)'(do_wr);
   assign rbin_nxt = rbin_r + (AW+1)'(do_rd);
   assign wr_ready = wgray_r != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
   assign rd_valid = rgray_r != wg_s2_r;
   assign rd_data  = mem[rbin_r[AW-1:0]];

   always_ff @(posedge wr_clk) begin
      if (do_wr) mem[wbin_r[AW-1:0]] <= wr_data;
   end

   always_ff @(posedge wr_clk or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         wbin_r  <= '0;
         wgray_r <= '0;
         rg_s1_r <= '0;
         rg_s2_r <= '0;
      end else begin
         wbin_r  <= wbin_nxt;
         wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
         rg_s1_r <= rgray_r;
         rg_s2_r <= rg_s1_r;
      end
   end

   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         rbin_r  <= '0;
         rgray_r <= '0;
         wg_s1_r <= '0;
         wg_s2_r <= '0;
      end else begin
         rbin_r  <= rbin_nxt;
         rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
         wg_s1_r <= wgray_r;
         wg_s2_r <= wg_s1_r;
      end
   end
endmodule

// ***********************************************
// Probe top
// ***********************************************
module tpc_probe
   import tpc_pkg::*;
#(
   parameter int FIFO_DEPTH = TPC_FIFO_DEPTH
) (
   // System
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Link
   tpc_if.probe             link,
   // Static configuration
   input  wire logic        capture_enable,
   input  wire tpc_arch_t   arch_version,
   input  wire tpc_width_t  port_width,
   input  wire logic        half_rate,
   // Captured sample stream
   output logic             sample_valid,
   input  wire logic        sample_ready,
   output tpc_sample_t      sample,
   output logic             overflow,
   // Run control requests
   input  wire logic        jtag_tck,
   input  wire logic        jtag_tms,
   input  wire logic        jtag_tdi,
   input  wire logic        jtag_trst_n,
   input  wire logic        halt_req,
   input  wire logic        target_reset,
   // Run control status
   output logic             jtag_tdo,
   output logic             jtag_returned_test_clock,
   output logic             halted
);
   localparam int SW = $bits(tpc_sample_t);
   localparam int FW = 2 * SW + 1;
   localparam int CW = 6;

   // ***********************************************
   // Link domain reset and configuration sync
   // ***********************************************
   wire         tclk = link.trace_port_clock;
   logic [1:0]  lrst_r;
   wire         lrst_n = lrst_r[1];
   logic [CW-1:0] cfg_s1_r, cfg_s2_r;
   wire [CW-1:0]  cfg_in = {capture_enable, half_rate, port_width, arch_version};

   always_ff @(posedge tclk or negedge rst_n) begin
      if (!rst_n) lrst_r <= 2'b00;
      else        lrst_r <= {lrst_r[0], 1'b1};
   end

   // Settings only change while capture is stopped
   always_ff @(posedge tclk or negedge lrst_n) begin
      if (!lrst_n) begin
         cfg_s1_r <= '0;
         cfg_s2_r <= '0;
      end else begin
         cfg_s1_r <= cfg_in;
         cfg_s2_r <= cfg_s1_r;
      end
   end

   wire         en_l   = cfg_s2_r[5];
   wire         half_l = cfg_s2_r[4];
   tpc_width_t  width_l;
   tpc_arch_t   arch_l;
   assign width_l = tpc_width_t'(cfg_s2_r[3:2]);
   assign arch_l  = tpc_arch_t'(cfg_s2_r[1:0]);
   wire [15:0]  mask_l = tpc_mask(width_l);

   // ***********************************************
   // Line capture on both clock edges
   // ***********************************************
   logic [TPC_LINES-1:0] rise_r, fall_r;
   logic                 rise_v_r, fall_v_r;
   logic                 wr_valid_r, ovf_l_r;
   logic [FW-1:0]        wr_data_r;
   logic                 fifo_wr_ready;
   wire                  wr_stall = wr_valid_r && !fifo_wr_ready;

   // Falling edge sample only counts after a counted rising one
   always_ff @(negedge tclk or negedge lrst_n) begin
      if (!lrst_n) begin
         fall_r   <= '0;
         fall_v_r <= 1'b0;
      end else begin
         fall_r   <= link.trace_lines;
         fall_v_r <= en_l && half_l && rise_v_r;
      end
   end

   always_ff @(posedge tclk or negedge lrst_n) begin
      if (!lrst_n) begin
         rise_r   <= '0;
         rise_v_r <= 1'b0;
      end else begin
         rise_r   <= link.trace_lines;
         rise_v_r <= en_l;
      end
   end

   // Pair rise then fall into one word, oldest first
   wire [FW-1:0] word_nxt = {fall_v_r, tpc_decode(fall_r, arch_l, mask_l),
                             tpc_decode(rise_r, arch_l, mask_l)};

   always_ff @(posedge tclk or negedge lrst_n) begin
      if (!lrst_n) begin
         wr_valid_r <= 1'b0;
         wr_data_r  <= '0;
         ovf_l_r    <= 1'b0;
      end else begin
         // Held word waits for the buffer; a newer word is dropped
         wr_valid_r <= rise_v_r || wr_stall;
         if (!wr_stall) wr_data_r <= word_nxt;
         if (rise_v_r && wr_stall) ovf_l_r <= 1'b1;
         else if (!en_l) ovf_l_r <= 1'b0;
      end
   end

   // ***********************************************
   // Crossing into the system domain
   // ***********************************************
   logic          rd_valid;
   logic [FW-1:0] rd_data;
   logic          sel_r;
   logic [1:0]    ovf_s_r;

   wire has_second = rd_data[FW-1];
   wire take       = sample_valid && sample_ready;
   wire last_half  = sel_r || !has_second;
   wire pop        = take && last_half;

   tpc_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) tpc_fifo_inst (
      .wr_clk   (tclk),
      .wr_rst_n (lrst_n),
      .wr_valid (wr_valid_r),
      .wr_ready (fifo_wr_ready),
      .wr_data  (wr_data_r),
      .rd_clk   (clock),
      .rd_rst_n (rst_n),
      .rd_valid (rd_valid),
      .rd_ready (pop),
      .rd_data  (rd_data)
   );

   assign sample_valid = rd_valid;
   assign sample       = sel_r ? rd_data[2*SW-1:SW] : rd_data[SW-1:0];
   assign overflow     = ovf_s_r[1];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sel_r   <= 1'b0;
         ovf_s_r <= 2'b00;
      end else begin
         if (take) sel_r <= !last_half;
         ovf_s_r <= {ovf_s_r[0], ovf_l_r};
      end
   end

   // ***********************************************
   // Run control
   // ***********************************************
   logic [3:0] jtag_r;
   logic       halt_req_r, reset_oe_r;
   logic [2:0] st_s1_r, st_s2_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         jtag_r     <= 4'h0;
         halt_req_r <= 1'b0;
         reset_oe_r <= 1'b0;
         st_s1_r    <= 3'h0;
         st_s2_r    <= 3'h0;
      end else begin
         jtag_r     <= {jtag_trst_n, jtag_tdi, jtag_tms, jtag_tck};
         halt_req_r <= halt_req;
         reset_oe_r <= target_reset;
         st_s1_r    <= {link.halt_acknowledge, link.returned_test_clock, link.tdo};
         st_s2_r    <= st_s1_r;
      end
   end

   assign link.tck          = jtag_r[0];
   assign link.tms          = jtag_r[1];
   assign link.tdi          = jtag_r[2];
   assign link.trst_n       = jtag_r[3];
   assign link.halt_request = halt_req_r;
   assign link.sys_reset_o  = 1'b0;
   assign link.sys_reset_oe = reset_oe_r;
   assign jtag_tdo          = st_s2_r[0];
   assign jtag_returned_test_clock         = st_s2_r[1];
   assign halted            = st_s2_r[2];
endmodule

// >>> verilog/tpc_target.sv
// Target end: drives trace lines and the trace port clock, answers JTAG and run control.
// Assumes the probe end drives JTAG, halt request and the open-collector reset.
module tpc_target
   import tpc_pkg::*;
#(
   parameter int TCLK_HALF = TPC_TCLK_HALF
) (
   // System
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Link
   tpc_if.target            link,
   // Static configuration
   input  wire tpc_arch_t   arch_version,
   input  wire logic        half_rate,
   // Sample source
   input  wire logic        src_valid,
   output logic             src_ready,
   input  wire tpc_sample_t src_sample,
   // Processor side
   input  wire logic        in_debug,
   input  wire logic        tdo_value,
   output logic             jtag_tck,
   output logic             jtag_tms,
   output logic             jtag_tdi,
   output logic             jtag_trst_n,
   output logic             halt_req,
   output logic             sys_reset_n
);
   localparam int CNT_W = $clog2(TCLK_HALF) + 1;
   localparam logic [CNT_W-1:0] CNT_END = CNT_W'(TCLK_HALF - 1);
   localparam logic [CNT_W-1:0] CNT_MID = CNT_W'(TCLK_HALF / 2);

   // ***********************************************
   // Trace clock divider and line driver
   // ***********************************************
   logic [CNT_W-1:0]     cnt_r;
   logic                 tclk_r;
   logic [TPC_LINES-1:0] lines_r;

   // Lines move mid-phase so both edges see stable data
   wire update = (cnt_r == CNT_MID) && (half_rate || !tclk_r);
   wire tpc_sample_t idle = '0;
   assign src_ready = update;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r   <= '0;
         tclk_r  <= 1'b0;
         lines_r <= '0;
      end else begin
         cnt_r <= (cnt_r == CNT_END) ? '0 : cnt_r + CNT_W'(1);
         if (cnt_r == CNT_END) tclk_r <= !tclk_r;
         if (update) lines_r <= tpc_encode(src_valid ? src_sample : idle, arch_version);
      end
   end

   // ***********************************************
   // JTAG and run control
   // ***********************************************
   logic [6:0] in_s1_r, in_s2_r;
   logic       tdo_r, ack_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         in_s1_r <= 7'h00;
         in_s2_r <= 7'h00;
         tdo_r   <= 1'b0;
         ack_r   <= 1'b0;
      end else begin
         in_s1_r <= {link.sys_reset_n, link.halt_request, link.trst_n, link.tdi,
                     link.tms, link.tck, 1'b0};
         in_s2_r <= in_s1_r;
         tdo_r   <= tdo_value;
         ack_r   <= in_debug;
      end
   end

   assign link.trace_port_clock    = tclk_r;
   assign link.trace_lines         = lines_r;
   assign link.tdo                 = tdo_r;
   assign link.returned_test_clock = in_s2_r[1];
   assign link.halt_acknowledge    = ack_r;
   assign jtag_tck                 = in_s2_r[1];
   assign jtag_tms                 = in_s2_r[2];
   assign jtag_tdi                 = in_s2_r[3];
   assign jtag_trst_n              = in_s2_r[4];
   assign halt_req                 = in_s2_r[5];
   assign sys_reset_n              = in_s2_r[6];
endmodule

// >>> test/tpc_asserts.sv
// Checker on the link signals joining the probe and target ends.
// Assumes both ends share one clock and reset; the trace clock is made from it.
module tpc_asserts
   import tpc_pkg::*;
#(
   parameter int TCLK_HALF = 4
) (
   // Clock and reset
   input wire logic                 clock,
   input wire logic                 rst_n,
   // Static configuration
   input wire tpc_arch_t            arch_version,
   input wire logic                 half_rate,
   // Link
   input wire logic                 trace_port_clock,
   input wire logic [TPC_LINES-1:0] trace_lines,
   input wire logic                 tck,
   input wire logic                 returned_test_clock,
   input wire logic                 sys_reset_o,
   input wire logic                 sys_reset_oe,
   input wire logic                 sys_reset_n
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // ********************************
   // Trace clock period counter
   // ********************************
   logic       tclk_d_r;
   logic       seen_r;
   logic [7:0] per_r;
   logic       rise;

   assign rise = trace_port_clock && !tclk_d_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tclk_d_r <= 1'b0;
         seen_r   <= 1'b0;
         per_r    <= 8'h00;
      end else begin
         tclk_d_r <= trace_port_clock;
         seen_r   <= seen_r | rise;
         per_r    <= rise ? 8'h01 : per_r + 8'h01;
      end
   end

   // ********************************
   // Properties
   // ********************************
   property p_oc_low_only;
      sys_reset_o == 1'b0;
   endproperty
   a_oc_low_only: assert property (p_oc_low_only)
      else $error("reset line driven high");

   property p_oc_pull;
      sys_reset_oe |-> !sys_reset_n;
   endproperty
   a_oc_pull: assert property (p_oc_pull)
      else $error("reset not pulled low");

   property p_oc_release;
      !sys_reset_oe |-> sys_reset_n;
   endproperty
   a_oc_release: assert property (p_oc_release)
      else $error("reset not released");

   property p_v3_fixed;
      arch_version == TPC_ARCH_V3 && rise |->
         trace_lines[TPC_L_ONE] && !trace_lines[TPC_L_ZERO0] && !trace_lines[TPC_L_ZERO1];
   endproperty
   a_v3_fixed: assert property (p_v3_fixed)
      else $error("fixed lines wrong");

   property p_edge_stable;
      $changed(trace_port_clock) |-> $stable(trace_lines);
   endproperty
   a_edge_stable: assert property (p_edge_stable)
      else $error("lines change at trace edge");

   property p_single_hold;
      !half_rate && $past(trace_port_clock) && trace_port_clock |-> $stable(trace_lines);
   endproperty
   a_single_hold: assert property (p_single_hold)
      else $error("lines change in high phase");

   property p_tclk_period;
      rise && seen_r |-> per_r == 8'(2 * TCLK_HALF);
   endproperty
   a_tclk_period: assert property (p_tclk_period)
      else $error("trace clock period wrong");

   property p_tclk_range;
      rise && seen_r |-> per_r >= 8'h01 && per_r <= 8'h0a;
   endproperty
   a_tclk_range: assert property (p_tclk_range)
      else $error("trace clock out of range");

   property p_returned_test_clock;
      returned_test_clock == $past(tck, 2);
   endproperty
   a_returned_test_clock: assert property (p_returned_test_clock)
      else $error("returned clock wrong");

   c_half: cover property (half_rate && rise);
   c_v3: cover property (arch_version == TPC_ARCH_V3 && rise);
   c_oc: cover property ($rose(sys_reset_oe));
endmodule

// >>> test/trace_port_capture_tb.sv
// Bench joining probe and target ends through the link interface.
// Assumes one 10 MHz clock for both ends; the target makes the trace clock.
module trace_port_capture_tb
   import tpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int THALF = 4;

   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        capture_enable = 1'b0;
   tpc_arch_t   arch_version = TPC_ARCH_V1;
   tpc_width_t  port_width = TPC_W16;
   logic        half_rate = 1'b0;
   logic        sample_ready = 1'b0;
   logic        stall = 1'b0;
   logic        src_valid = 1'b0;
   tpc_sample_t src_sample = '0;
   logic        jtag_tck = 1'b0;
   logic        jtag_tms = 1'b0;
   logic        jtag_tdi = 1'b0;
   logic        jtag_trst_n = 1'b1;
   logic        halt_req = 1'b0;
   logic        target_reset = 1'b0;
   logic        in_debug = 1'b0;
   logic        tdo_value = 1'b0;
   logic        sample_valid, overflow, src_ready, jtag_tdo, jtag_returned_test_clock, halted;
   logic        tg_tck, tg_tms, tg_tdi, tg_trst_n, tg_halt, tg_rst_n;
   tpc_sample_t sample;
   tpc_sample_t exp_q[$];
   tpc_sample_t exp_s;
   integer      seed = 42;
   int          n_mismatch = 0;
   int          checked = 0;

   initial forever #50 clock = ~clock;

   // ********************************
   // Design
   // ********************************
   tpc_if link_if ();

   tpc_probe #(.FIFO_DEPTH(TPC_FIFO_DEPTH)) tpc_probe_inst (
      .clock(clock), .rst_n(rst_n), .link(link_if), .capture_enable(capture_enable),
      .arch_version(arch_version), .port_width(port_width), .half_rate(half_rate),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sample(sample),
      .overflow(overflow), .jtag_tck(jtag_tck), .jtag_tms(jtag_tms), .jtag_tdi(jtag_tdi),
      .jtag_trst_n(jtag_trst_n), .halt_req(halt_req), .target_reset(target_reset),
      .jtag_tdo(jtag_tdo), .jtag_returned_test_clock(jtag_returned_test_clock), .halted(halted));

   tpc_target #(.TCLK_HALF(THALF)) tpc_target_inst (
      .clock(clock), .rst_n(rst_n), .link(link_if), .arch_version(arch_version),
      .half_rate(half_rate), .src_valid(src_valid), .src_ready(src_ready),
      .src_sample(src_sample), .in_debug(in_debug), .tdo_value(tdo_value),
      .jtag_tck(tg_tck), .jtag_tms(tg_tms), .jtag_tdi(tg_tdi), .jtag_trst_n(tg_trst_n),
      .halt_req(tg_halt), .sys_reset_n(tg_rst_n));

   tpc_asserts #(.TCLK_HALF(THALF)) tpc_asserts_inst (
      .clock(clock), .rst_n(rst_n), .arch_version(arch_version), .half_rate(half_rate),
      .trace_port_clock(link_if.trace_port_clock), .trace_lines(link_if.trace_lines),
      .tck(link_if.tck), .returned_test_clock(link_if.returned_test_clock),
      .sys_reset_o(link_if.sys_reset_o), .sys_reset_oe(link_if.sys_reset_oe),
      .sys_reset_n(link_if.sys_reset_n));

   // ********************************
   // Helpers
   // ********************************
   task automatic stop_test();
      if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic fail_now(input string msg);
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
      stop_test();
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      tick(20);
      rst_n <= 1'b1;
   endtask

   // Payload bit 0 set so a sent sample never looks idle
   function automatic tpc_sample_t rnd_sample();
      tpc_sample_t s;
      s = tpc_sample_t'(22'($random(seed)));
      s.payload[0] = 1'b1;
      return s;
   endfunction

   function automatic tpc_sample_t expect_of(tpc_sample_t s);
      tpc_sample_t e;
      e = '0;
      e.payload = s.payload & (port_width == TPC_W4 ? TPC_MASK_W4 :
                               port_width == TPC_W8 ? TPC_MASK_W8 : TPC_MASK_W16);
      if (arch_version == TPC_ARCH_V1) begin
         e.pipeline_status[2:0] = s.pipeline_status[2:0];
         e.branch_sync_marker   = s.branch_sync_marker;
      end
      if (arch_version == TPC_ARCH_V2) e.pipeline_status = s.pipeline_status;
      if (arch_version == TPC_ARCH_V3) e.trace_valid_control = s.trace_valid_control;
      return e;
   endfunction

   // Random consumer stalls; idle words are skipped
   always @(posedge clock) sample_ready <= !stall && 1'($random(seed));

   always @(posedge clock) begin
      if (rst_n && sample_valid === 1'b1 && sample_ready && sample !== '0) begin
         exp_s = exp_q.size() > 0 ? exp_q.pop_front() : '0;
         check(64'(sample), 64'(exp_s));
      end
   end

   // ********************************
   // Scenarios
   // ********************************
   task automatic run_ctrl();
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         {jtag_tck, jtag_tms, jtag_tdi, jtag_trst_n} <= 4'($random(seed));
         {halt_req, target_reset, in_debug, tdo_value} <= 4'($random(seed));
         tick(10);
         check({tg_tck, tg_tms}, {jtag_tck, jtag_tms});
         check({tg_tdi, tg_trst_n}, {jtag_tdi, jtag_trst_n});
         check({tg_halt, jtag_tdo}, {halt_req, tdo_value});
         check(tg_rst_n, !target_reset);
         check(halted, in_debug);
         check(jtag_returned_test_clock, jtag_tck);
      end
   endtask

   task automatic run_cfg(input tpc_arch_t a, input tpc_width_t w, input logic h);
      int n;
      int t;
      @(posedge clock);
      capture_enable <= 1'b0;
      arch_version   <= a;
      port_width     <= w;
      half_rate      <= h;
      do_reset();
      tick(30);
      capture_enable <= 1'b1;
      tick(40);
      n = 0;
      src_valid  <= 1'b1;
      src_sample <= rnd_sample();
      for (t = 0; t < 400 && n < 8; t++) begin
         @(posedge clock);
         if (src_ready && src_valid) begin
            exp_q.push_back(expect_of(src_sample));
            n++;
            src_sample <= rnd_sample();
            if (n == 8) src_valid <= 1'b0;
         end
      end
      if (n < 8) fail_now("source never taken");
      for (t = 0; t < 800 && exp_q.size() > 0; t++) @(posedge clock);
      if (exp_q.size() > 0) fail_now("samples missing");
   endtask

   initial begin
      int t;
      tick(20);
      rst_n <= 1'b1;
      tick(5);
      run_ctrl();
      for (int a = 0; a < 3; a++) begin
         for (int w = 0; w < 3; w++) begin
            for (int h = 0; h < 2; h++) begin
               run_cfg(tpc_arch_t'(a), tpc_width_t'(w), h[0]);
            end
         end
      end
      // Fill the buffer until it drops words, then drain it
      stall <= 1'b1;
      tick(40 * 2 * THALF);
      check(overflow, 1'b1);
      stall          <= 1'b0;
      capture_enable <= 1'b0;
      for (t = 0; t < 400 && sample_valid !== 1'b0; t++) @(posedge clock);
      if (sample_valid !== 1'b0) fail_now("buffer never drained");
      tick(10);
      check({sample_valid, overflow}, 2'b00);
      stop_test();
   end
endmodule
